/* File: tb/odc_bank_bench.sv */
// Self-checking bench for the output divider and driver configuration bank
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module odc_bank_bench
	import odc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid;
	logic [7:0] reg_addr, ch5_integer_divider;
	logic [15:0] reg_wdata, reg_rdata, d, lo;
	logic [8:0] ch5_int_ratio;
	logic [19:0] ch5_fractional_divider;
	logic [11:0] ch6_div_raw;
	odc_ch6_cfg_t ch6_cfg;
	logic [7:0] v;
	logic [3:0] fh;
	logic [1:0] c;
	logic fe;
	int err_total = 0;
	int checks_done = 0;
	logic [2:0] pre_c [4] = '{3'h0, 3'h1, 3'h7, 3'h0};
	logic [1:0] ratio_e [4] = '{PRE_RATIO_2, PRE_RATIO_3, PRE_RATIO_1, PRE_RATIO_2};
	odc_drv_t drv_e [4] = '{DRV_LVDS, DRV_LVDS, DRV_LVCMOS, DRV_HCSL};
	odc_out_t out_e [4] = '{OUT_DISABLED, OUT_ENABLED, OUT_STATIC_LOW, OUT_STATIC_HIGH};

	odc_bank odc_bank_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid), .ch5_integer_divider(ch5_integer_divider),
		.ch5_int_ratio(ch5_int_ratio), .ch5_fractional_divider(ch5_fractional_divider),
		.ch6_cfg(ch6_cfg), .ch6_div_raw(ch6_div_raw)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	// Returns once the decoded outputs have taken the new value
	task automatic wr(input logic [7:0] a, input logic [15:0] wd);
		@(posedge clk_sys);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wdata <= wd;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
		@(posedge clk_sys);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		#1;
		`CHK("rd_valid", 1'b1, reg_rd_valid)
		`CHK("rdata", e, reg_rdata)
	endtask

	task automatic results();
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial
	begin
		repeat (2000) @(posedge clk_sys);
		err_total++;
		results();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		rst_n = 1'b0;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		`CHK("ratio_rst", INT_RATIO_ONE, ch5_int_ratio)
		`CHK("frac_rst", FRAC_RST, ch5_fractional_divider)
		`CHK("ch6_rst", CH6_CFG_RST, ch6_cfg)
		for (int k = 0; k < 5; k++)
			rd(ADDR_CH5_INT_FRAC_HI + 8'(k), 16'h0000);
		// Fraction halves land separately
		lo = 16'h0000;
		for (int k = 0; k < 2; k++)
		begin
			v = k ? 8'hff : 8'h00;
			fh = k ? 4'h9 : 4'h6;
			wr(ADDR_CH5_INT_FRAC_HI, {4'h0, v, fh});
			`CHK("int_div", v, ch5_integer_divider)
			`CHK("int_ratio", {1'b0, v} + 9'h001, ch5_int_ratio)
			`CHK("frac_hi", {fh, lo}, ch5_fractional_divider)
			lo = k ? 16'h1234 : 16'hedcb;
			wr(ADDR_CH5_FRAC_LO, lo);
			`CHK("frac_lo", {fh, lo}, ch5_fractional_divider)
			rd(ADDR_CH5_INT_FRAC_HI, {4'h0, v, fh});
			rd(ADDR_CH5_FRAC_LO, lo);
		end
		// Pre-divider codes 000, 001 and 111, and every driver and output code
		for (int i = 0; i < 4; i++)
		begin
			c = 2'(i);
			fe = (i != 3);
			d = {3'h0, pre_c[i], fe, c[0], c == 2'h3, c != 2'h0, 1'b0, c, ~c, c[1]};
			wr(ADDR_CH6_DRV_CFG, d);
			`CHK("frac_en", fe, ch6_cfg.frac_enable)
			`CHK("bypass", ~fe, ch6_cfg.pre_div_bypass)
			if (fe)
				`CHK("pre_ratio", ratio_e[i], ch6_cfg.pre_div_ratio)
			`CHK("pre_rsv", 1'b0, ch6_cfg.pre_div_reserved)
			`CHK("slew", c[0], ch6_cfg.slew_slow)
			`CHK("pos_en", c != 2'h0, ch6_cfg.pos_enable)
			`CHK("neg_en", c == 2'h3, ch6_cfg.neg_enable)
			`CHK("driver", drv_e[c], ch6_cfg.driver)
			`CHK("out_ctl", out_e[~c], ch6_cfg.output_ctl)
			`CHK("supply", c[1], ch6_cfg.supply_high)
			rd(ADDR_CH6_DRV_CFG, d);
		end
		wr(ADDR_CH6_INT_FRAC_HI, 16'h0a5c);
		`CHK("ch6_raw", 12'ha5c, ch6_div_raw)
		rd(ADDR_CH6_INT_FRAC_HI, 16'h0a5c);
		// Unmapped place is ignored and reads zero
		wr(8'h11, 16'h5555);
		rd(8'h11, 16'h0000);
		rd(ADDR_CH6_DRV_CFG, d);
		`CHK("ch6_keep", 12'ha5c, ch6_div_raw)
		results();
	end

endmodule // odc_bank_bench

/* File: verilog/odc_bank.sv */
// Output divider and driver configuration bank for channels 5 and 6
// Behaviour
// - Channel 5 integer divide ratio is bits 11:4 of its register plus one.
// - Channel 5 fraction is 4 high bits 3:0 joined with next register's 16.
// - Channel 6 pre-divider: 000 divides by two, 001 three, 111 one.
// - Channel 6 pre-divider bypassed whenever its fractional enable is clear.
// - Channel 6 fractional divider enabled by bit 9 set, disabled when clear.
// - Channel 6 bit 8 chooses normal slew when zero, slow when one.
// - Channel 6 bits 4:3 select LVDS for 00/01, LVCMOS 10, HCSL 11.
// - Channel 6 bits 2:1: off, on, static low, static high.
// - Bit 0 picks low or high supply; zero at power-up is tolerated.
module odc_bank
	import odc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register access from the serial programming port
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rd_valid,
	// Channel 5 divider settings
	output logic [7:0] ch5_integer_divider,
	output logic [8:0] ch5_int_ratio,
	output logic [19:0] ch5_fractional_divider,
	// Channel 6 settings
	output odc_ch6_cfg_t ch6_cfg,
	output logic [11:0] ch6_div_raw
);

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [15:0] r13;
	logic [15:0] r14;
	logic [15:0] r15;
	logic [15:0] r16;
	logic wr13;
	logic wr14;
	logic wr15;
	logic wr16;

	always_comb
	begin
		wr13 = 1'b0;
		wr14 = 1'b0;
		wr15 = 1'b0;
		wr16 = 1'b0;
		if (reg_wr_en && reg_addr == ADDR_CH5_INT_FRAC_HI)
		begin
			wr13 = 1'b1;
		end
		else if (reg_wr_en && reg_addr == ADDR_CH5_FRAC_LO)
		begin
			wr14 = 1'b1;
		end
		else if (reg_wr_en && reg_addr == ADDR_CH6_DRV_CFG)
		begin
			wr15 = 1'b1;
		end
		else if (reg_wr_en && reg_addr == ADDR_CH6_INT_FRAC_HI)
		begin
			wr16 = 1'b1;
		end
	end

	odc_cfg_reg #(.MASK(MASK_CH5_INT_FRAC_HI)) u_r13 (
		.clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr13), .wdata(reg_wdata), .q(r13));
	odc_cfg_reg #(.MASK(MASK_CH5_FRAC_LO)) u_r14 (
		.clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr14), .wdata(reg_wdata), .q(r14));
	odc_cfg_reg #(.MASK(MASK_CH6_DRV_CFG)) u_r15 (
		.clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr15), .wdata(reg_wdata), .q(r15));
	odc_cfg_reg #(.MASK(MASK_CH6_INT_FRAC_HI)) u_r16 (
		.clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr16), .wdata(reg_wdata), .q(r16));

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	logic rd_valid_ff;
	logic nxt_rd_valid;

	always_comb
	begin
		nxt_rd_valid = reg_rd_en;
		nxt_rdata = RDATA_ZERO;
		if (!reg_rd_en)
		begin
			nxt_rdata = RDATA_ZERO;
		end
		else if (reg_addr == ADDR_CH5_INT_FRAC_HI)
		begin
			nxt_rdata = r13;
		end
		else if (reg_addr == ADDR_CH5_FRAC_LO)
		begin
			nxt_rdata = r14;
		end
		else if (reg_addr == ADDR_CH6_DRV_CFG)
		begin
			nxt_rdata = r15;
		end
		else if (reg_addr == ADDR_CH6_INT_FRAC_HI)
		begin
			nxt_rdata = r16;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			rdata_ff <= RDATA_ZERO;
			rd_valid_ff <= 1'b0;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
			rd_valid_ff <= nxt_rd_valid;
		end
	end

	// ----------------------------------------
	// Divider and driver decode
	// ----------------------------------------
	logic [7:0] int_div_ff;
	logic [7:0] nxt_int_div;
	logic [8:0] int_ratio_ff;
	logic [8:0] nxt_int_ratio;
	logic [19:0] frac_ff;
	logic [19:0] nxt_frac;
	odc_ch6_cfg_t ch6_ff;
	odc_ch6_cfg_t nxt_ch6;
	logic [11:0] ch6_div_ff;
	logic [11:0] nxt_ch6_div;

	always_comb
	begin
		nxt_int_div = r13[INT_DIV_MSB:INT_DIV_LSB];
		nxt_int_ratio = {1'b0, r13[INT_DIV_MSB:INT_DIV_LSB]} + INT_RATIO_ONE;
		nxt_frac = {r13[FRAC_HI_MSB:FRAC_HI_LSB], r14};
		nxt_ch6_div = r16[INT_DIV_MSB:FRAC_HI_LSB];
		nxt_ch6 = CH6_CFG_RST;
		nxt_ch6.frac_enable = r15[FRAC_EN_BIT];
		nxt_ch6.slew_slow = r15[SLEW_BIT];
		nxt_ch6.pos_enable = r15[POS_EN_BIT];
		nxt_ch6.neg_enable = r15[NEG_EN_BIT] & r15[POS_EN_BIT];
		nxt_ch6.supply_high = r15[SUPPLY_BIT];
		// Reserved pre-divider codes fall back to divide by one
		case (r15[PRE_DIV_MSB:PRE_DIV_LSB])
			PRE_CODE_DIV2: nxt_ch6.pre_div_ratio = PRE_RATIO_2;
			PRE_CODE_DIV3: nxt_ch6.pre_div_ratio = PRE_RATIO_3;
			PRE_CODE_DIV1: nxt_ch6.pre_div_ratio = PRE_RATIO_1;
			default:
			begin
				nxt_ch6.pre_div_ratio = PRE_RATIO_1;
				nxt_ch6.pre_div_reserved = 1'b1;
			end
		endcase
		nxt_ch6.pre_div_bypass = ~r15[FRAC_EN_BIT];
		if (!r15[FRAC_EN_BIT])
		begin
			nxt_ch6.pre_div_ratio = PRE_RATIO_1;
		end
		case (r15[DRV_MSB:DRV_LSB])
			DRV_CODE_LVDS0: nxt_ch6.driver = DRV_LVDS;
			DRV_CODE_LVDS1: nxt_ch6.driver = DRV_LVDS;
			DRV_CODE_LVCMOS: nxt_ch6.driver = DRV_LVCMOS;
			default: nxt_ch6.driver = DRV_HCSL;
		endcase
		case (r15[OUT_MSB:OUT_LSB])
			OUT_CODE_OFF: nxt_ch6.output_ctl = OUT_DISABLED;
			OUT_CODE_ON: nxt_ch6.output_ctl = OUT_ENABLED;
			OUT_CODE_LOW: nxt_ch6.output_ctl = OUT_STATIC_LOW;
			default: nxt_ch6.output_ctl = OUT_STATIC_HIGH;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			int_div_ff <= '0;
			int_ratio_ff <= INT_RATIO_ONE;
			frac_ff <= FRAC_RST;
			ch6_ff <= CH6_CFG_RST;
			ch6_div_ff <= CH6_DIV_RST;
		end
		else
		begin
			int_div_ff <= nxt_int_div;
			int_ratio_ff <= nxt_int_ratio;
			frac_ff <= nxt_frac;
			ch6_ff <= nxt_ch6;
			ch6_div_ff <= nxt_ch6_div;
		end
	end

	assign reg_rdata = rdata_ff;
	assign reg_rd_valid = rd_valid_ff;
	assign ch5_integer_divider = int_div_ff;
	assign ch5_int_ratio = int_ratio_ff;
	assign ch5_fractional_divider = frac_ff;
	assign ch6_cfg = ch6_ff;
	assign ch6_div_raw = ch6_div_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_INT_RATIO: assert property (
		wr13 ##1 !wr13 |=> int_ratio_ff ==
			{1'b0, $past(reg_wdata[INT_DIV_MSB:INT_DIV_LSB], 2)} + INT_RATIO_ONE)
		else $error("channel 5 ratio wrong");
	AST_FRAC_JOIN: assert property (
		wr14 ##1 !wr13 |=> frac_ff[15:0] == $past(reg_wdata, 2))
		else $error("channel 5 fraction low half wrong");
	AST_PRE_DIV3: assert property (
		wr15 && reg_wdata[FRAC_EN_BIT] && reg_wdata[PRE_DIV_MSB:PRE_DIV_LSB] == PRE_CODE_DIV3
		##1 !wr15 |=> ch6_ff.pre_div_ratio == PRE_RATIO_3 && !ch6_ff.pre_div_bypass)
		else $error("divide by three not decoded");
	AST_BYPASS: assert property (
		!ch6_ff.frac_enable |-> ch6_ff.pre_div_bypass && ch6_ff.pre_div_ratio == PRE_RATIO_1)
		else $error("pre-divider not bypassed");
	AST_FRAC_EN: assert property (
		ch6_ff.frac_enable == $past(r15[FRAC_EN_BIT]))
		else $error("fractional enable mismatch");
	AST_SLEW: assert property (
		wr15 ##1 !wr15 |=> ch6_ff.slew_slow == $past(reg_wdata[SLEW_BIT], 2))
		else $error("slew select mismatch");
	AST_NEG_GATED: assert property (
		ch6_ff.neg_enable |-> ch6_ff.pos_enable)
		else $error("negative side on without positive side");
	AST_DRIVER: assert property (
		$past(r15[DRV_MSB:DRV_LSB]) == DRV_CODE_LVCMOS |-> ch6_ff.driver == DRV_LVCMOS)
		else $error("driver type mismatch");
	AST_OUT_HIGH: assert property (
		wr15 && reg_wdata[OUT_MSB:OUT_LSB] == OUT_CODE_HIGH ##1 !wr15
		|=> ch6_ff.output_ctl == OUT_STATIC_HIGH)
		else $error("static high not selected");
	AST_RESERVED_ZERO: assert property (
		reg_rd_en && reg_addr == ADDR_CH6_DRV_CFG |=> (rdata_ff & ~MASK_CH6_DRV_CFG) == RDATA_ZERO
			&& rd_valid_ff)
		else $error("reserved bits read nonzero");
	AST_SUPPLY: assert property (
		ch6_ff.supply_high == $past(r15[SUPPLY_BIT]))
		else $error("supply range mismatch");

	COV_DIV3: cover property (wr15 ##2 ch6_ff.pre_div_ratio == PRE_RATIO_3);
	COV_HCSL: cover property (ch6_ff.driver == DRV_HCSL);
	COV_STATIC_HIGH: cover property (ch6_ff.output_ctl == OUT_STATIC_HIGH);
	COV_READ_BACK: cover property (wr14 ##[1:4] reg_rd_en && reg_addr == ADDR_CH5_FRAC_LO);

endmodule // odc_bank

/* File: verilog/odc_cfg_reg.sv */
// One 16-bit configuration register with reserved bits held at zero
module odc_cfg_reg
	import odc_pkg::*;
#(
	parameter logic [15:0] MASK = 16'hffff
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Write side
	input wire logic wr_en,
	input wire logic [15:0] wdata,
	// Stored value
	output logic [15:0] q
);

	logic [15:0] q_ff;
	logic [15:0] nxt_q;

	always_comb
	begin
		nxt_q = q_ff;
		if (wr_en)
		begin
			nxt_q = wdata & MASK;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			q_ff <= REG_RST;
		end
		else
		begin
			q_ff <= nxt_q;
		end
	end

	assign q = q_ff;

endmodule // odc_cfg_reg

/* File: verilog/odc_pkg.sv */
// Package: register map, field layout, decode codes and types for the output config bank
package odc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CH5_INT_FRAC_HI = 8'h0d;
	localparam logic [7:0] ADDR_CH5_FRAC_LO = 8'h0e;
	localparam logic [7:0] ADDR_CH6_DRV_CFG = 8'h0f;
	localparam logic [7:0] ADDR_CH6_INT_FRAC_HI = 8'h10;

	// Writable bits per register; reserved bits are held at zero
	localparam logic [15:0] MASK_CH5_INT_FRAC_HI = 16'h0fff;
	localparam logic [15:0] MASK_CH5_FRAC_LO = 16'hffff;
	localparam logic [15:0] MASK_CH6_DRV_CFG = 16'h1fdf;
	localparam logic [15:0] MASK_CH6_INT_FRAC_HI = 16'h0fff;
	localparam logic [15:0] REG_RST = 16'h0000;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int INT_DIV_MSB = 11;
	localparam int INT_DIV_LSB = 4;
	localparam int FRAC_HI_MSB = 3;
	localparam int FRAC_HI_LSB = 0;
	localparam int PRE_DIV_MSB = 12;
	localparam int PRE_DIV_LSB = 10;
	localparam int FRAC_EN_BIT = 9;
	localparam int SLEW_BIT = 8;
	localparam int NEG_EN_BIT = 7;
	localparam int POS_EN_BIT = 6;
	localparam int DRV_MSB = 4;
	localparam int DRV_LSB = 3;
	localparam int OUT_MSB = 2;
	localparam int OUT_LSB = 1;
	localparam int SUPPLY_BIT = 0;

	// ----------------------------------------
	// Codes
	// ----------------------------------------
	localparam logic [2:0] PRE_CODE_DIV2 = 3'h0;
	localparam logic [2:0] PRE_CODE_DIV3 = 3'h1;
	localparam logic [2:0] PRE_CODE_DIV1 = 3'h7;
	localparam logic [1:0] PRE_RATIO_1 = 2'h1;
	localparam logic [1:0] PRE_RATIO_2 = 2'h2;
	localparam logic [1:0] PRE_RATIO_3 = 2'h3;
	localparam logic [1:0] DRV_CODE_LVDS0 = 2'h0;
	localparam logic [1:0] DRV_CODE_LVDS1 = 2'h1;
	localparam logic [1:0] DRV_CODE_LVCMOS = 2'h2;
	localparam logic [1:0] DRV_CODE_HCSL = 2'h3;
	localparam logic [1:0] OUT_CODE_OFF = 2'h0;
	localparam logic [1:0] OUT_CODE_ON = 2'h1;
	localparam logic [1:0] OUT_CODE_LOW = 2'h2;
	localparam logic [1:0] OUT_CODE_HIGH = 2'h3;
	localparam logic [8:0] INT_RATIO_ONE = 9'h001;
	localparam logic [19:0] FRAC_RST = 20'h0_0000;
	localparam logic [11:0] CH6_DIV_RST = 12'h000;
	localparam logic [15:0] RDATA_ZERO = 16'h0000;

	typedef enum logic [2:0] {
		DRV_LVDS = 3'h1,
		DRV_LVCMOS = 3'h2,
		DRV_HCSL = 3'h4
	} odc_drv_t;

	typedef enum logic [3:0] {
		OUT_DISABLED = 4'h1,
		OUT_ENABLED = 4'h2,
		OUT_STATIC_LOW = 4'h4,
		OUT_STATIC_HIGH = 4'h8
	} odc_out_t;

	typedef struct packed {
		logic [1:0] pre_div_ratio;
		logic pre_div_reserved;
		logic pre_div_bypass;
		logic frac_enable;
		logic slew_slow;
		logic pos_enable;
		logic neg_enable;
		odc_drv_t driver;
		odc_out_t output_ctl;
		logic supply_high;
	} odc_ch6_cfg_t;

	// Decode of an all-zero configuration register
	localparam odc_ch6_cfg_t CH6_CFG_RST = '{
		pre_div_ratio: PRE_RATIO_1,
		pre_div_reserved: 1'b0,
		pre_div_bypass: 1'b1,
		frac_enable: 1'b0,
		slew_slow: 1'b0,
		pos_enable: 1'b0,
		neg_enable: 1'b0,
		driver: DRV_LVDS,
		output_ctl: OUT_DISABLED,
		supply_high: 1'b0
	};

endpackage : odc_pkg
